// ### core/pmb_pkg.sv
// Purpose: Shared constants and types of the management port block.
// Assumes: One 8-bit control register on the documented register port.
// Notes:   Field positions follow the control register layout.
package pmb_pkg;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] CTRL_OFFSET = 8'h76;
   localparam logic [7:0] CTRL_RESET  = 8'h00;
   localparam int         CTRL_W      = 8;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int BIT_CLK      = 0;
   localparam int BIT_DATA     = 1;
   localparam int BIT_OE       = 2;
   localparam int BIT_DPX_POL  = 3;
   localparam int BIT_DPX_ST   = 4;
   localparam int BIT_LNK_POL  = 5;
   localparam int BIT_RATE_LO  = 6;
   localparam int BIT_RATE_HI  = 7;

   // Bits software may change; the rest are status.
   localparam logic [7:0] CTRL_WMASK = 8'h2F;

   // ----------------------------------------
   // Link rate codes
   // ----------------------------------------
   typedef enum logic [1:0] {
      RATE_DOWN  = 2'b00,
      RATE_10    = 2'b01,
      RATE_100   = 2'b10,
      RATE_1000  = 2'b11
   } pmb_rate_t;

   // ----------------------------------------
   // Indication pins as one group
   // ----------------------------------------
   typedef struct packed {
      logic duplex;
      logic link_10;
      logic link_100;
      logic link_1000;
   } pmb_ind_t;

   localparam int IND_W = 4;
   localparam logic [3:0] IND_RESET = 4'hF;

   // ----------------------------------------
   // Synchroniser depth
   // ----------------------------------------
   localparam int SYNC_STAGES = 2;

endpackage

// ### core/pmb_sync.sv
// Purpose: Two-flop synchroniser for a bus of level signals.
// Assumes: Each bit is a slow level; no bus coherence is needed.
// Notes:   The first stage feeds only the second stage.
module pmb_sync #(
   parameter int            WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             i_core_clk,
   input  wire logic             i_rstn,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] meta_r;

   // ----------------------------------------
   // Two sampling stages
   // ----------------------------------------
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         meta_r <= RST_VAL;
         o_sync <= RST_VAL;
      end else begin
         meta_r <= i_async;
         o_sync <= meta_r;
      end
   end

endmodule

// ### core/pmb_mgmt_port.sv
// Purpose: Bit-banged two-wire management port with PHY status sensing.
// Assumes: Software toggles the clock and data through the control register.
// Notes:   No serial sequencing here; waveform timing belongs to software.
//
// What this block does
// - Clock line follows control bit 0 directly.
// - Output enabled drives data line from bit 1.
// - Output disabled releases line; bit 1 reads line.
// - Control bit 2 is the data output enable.
// - Duplex polarity 0 makes duplex pin active low.
// - Bit 4 reads 1 when PHY is full duplex.
// - Link polarity 0 makes link pins active low.
// - Bits 7:6 give live link rate code.
// - One port serves external PHY and internal PCS.
module pmb_mgmt_port (
   input  wire logic       i_core_clk,
   input  wire logic       i_rstn,
   // Register port.
   input  wire logic [7:0] i_reg_addr,
   input  wire logic       i_reg_wr,
   input  wire logic       i_reg_rd,
   input  wire logic [7:0] i_reg_wdata,
   output logic      [7:0] o_reg_rdata,
   output logic            o_reg_rvalid,
   // External management pins.
   output logic            o_mdc,
   input  wire logic       i_mdio_in,
   output logic            o_mdio_out,
   output logic            o_mdio_oe,
   // Internal PCS management side.
   output logic            o_pcs_mdc,
   output logic            o_pcs_mdio,
   input  wire logic       i_pcs_mdio_out,
   input  wire logic       i_pcs_mdio_oe,
   // PHY indication pins.
   input  wire logic       i_duplex_indication_pin,
   input  wire logic       i_link_10_indication_pin,
   input  wire logic       i_link_100_indication_pin,
   input  wire logic       i_link_1000_indication_pin,
   // Live status for the MAC.
   output logic            o_duplex_full,
   output logic      [1:0] o_link_rate
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [7:0]         ctrl_r;
   logic [7:0]         ctrl_nxt;
   logic               mdio_ext_s;
   pmb_pkg::pmb_ind_t  ind_raw;
   pmb_pkg::pmb_ind_t  ind_s;
   pmb_pkg::pmb_ind_t  ind_act;
   logic               mdio_line;
   logic               dpx_r;
   logic [1:0]         rate_r;
   pmb_pkg::pmb_rate_t rate_nxt;
   logic               sel;
   logic [7:0]         rd_val;

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   assign sel = (i_reg_addr == pmb_pkg::CTRL_OFFSET);

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   assign ind_raw = '{duplex:    i_duplex_indication_pin,
                      link_10:   i_link_10_indication_pin,
                      link_100:  i_link_100_indication_pin,
                      link_1000: i_link_1000_indication_pin};

   pmb_sync #(
      .WIDTH   (pmb_pkg::IND_W),
      .RST_VAL (pmb_pkg::IND_RESET)
   ) u_sync_ind (
      .i_core_clk (i_core_clk),
      .i_rstn     (i_rstn),
      .i_async    (ind_raw),
      .o_sync     (ind_s)
   );

   pmb_sync #(
      .WIDTH   (1),
      .RST_VAL (1'b1)
   ) u_sync_mdio (
      .i_core_clk (i_core_clk),
      .i_rstn     (i_rstn),
      .i_async    (i_mdio_in),
      .o_sync     (mdio_ext_s)
   );

   // ----------------------------------------
   // Shared data line seen by the port
   // ----------------------------------------
   // The PCS answers on the same line as an external PHY.
   always_comb begin
      if (i_pcs_mdio_oe) begin
         mdio_line = i_pcs_mdio_out;
      end else begin
         mdio_line = mdio_ext_s;
      end
   end

   // ----------------------------------------
   // Control register
   // ----------------------------------------
   always_comb begin
      ctrl_nxt = ctrl_r;
      if (i_reg_wr && sel) begin
         ctrl_nxt = (i_reg_wdata & pmb_pkg::CTRL_WMASK)
                  | (ctrl_r & ~pmb_pkg::CTRL_WMASK);
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ctrl_r <= pmb_pkg::CTRL_RESET;
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   // ----------------------------------------
   // Pin drive
   // ----------------------------------------
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_mdc      <= 1'b0;
         o_pcs_mdc  <= 1'b0;
         o_mdio_out <= 1'b0;
         o_mdio_oe  <= 1'b0;
         o_pcs_mdio <= 1'b1;
      end else begin
         o_mdc      <= ctrl_nxt[pmb_pkg::BIT_CLK];
         o_pcs_mdc  <= ctrl_nxt[pmb_pkg::BIT_CLK];
         o_mdio_out <= ctrl_nxt[pmb_pkg::BIT_DATA];
         o_mdio_oe  <= ctrl_nxt[pmb_pkg::BIT_OE];
         if (ctrl_nxt[pmb_pkg::BIT_OE]) begin
            o_pcs_mdio <= ctrl_nxt[pmb_pkg::BIT_DATA];
         end else begin
            o_pcs_mdio <= mdio_ext_s;
         end
      end
   end

   // ----------------------------------------
   // Indication polarity
   // ----------------------------------------
   always_comb begin
      ind_act.duplex = ctrl_r[pmb_pkg::BIT_DPX_POL] ?
                       ind_s.duplex : ~ind_s.duplex;
      ind_act.link_10 = ctrl_r[pmb_pkg::BIT_LNK_POL] ?
                        ind_s.link_10 : ~ind_s.link_10;
      ind_act.link_100 = ctrl_r[pmb_pkg::BIT_LNK_POL] ?
                         ind_s.link_100 : ~ind_s.link_100;
      ind_act.link_1000 = ctrl_r[pmb_pkg::BIT_LNK_POL] ?
                          ind_s.link_1000 : ~ind_s.link_1000;
   end

   // ----------------------------------------
   // Link rate decode, fastest indication wins
   // ----------------------------------------
   always_comb begin
      if (ind_act.link_1000) begin
         rate_nxt = pmb_pkg::RATE_1000;
      end else if (ind_act.link_100) begin
         rate_nxt = pmb_pkg::RATE_100;
      end else if (ind_act.link_10) begin
         rate_nxt = pmb_pkg::RATE_10;
      end else begin
         rate_nxt = pmb_pkg::RATE_DOWN;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         dpx_r         <= 1'b0;
         rate_r        <= pmb_pkg::RATE_DOWN;
         o_duplex_full <= 1'b0;
         o_link_rate   <= pmb_pkg::RATE_DOWN;
      end else begin
         dpx_r         <= ind_act.duplex;
         rate_r        <= rate_nxt;
         o_duplex_full <= ind_act.duplex;
         o_link_rate   <= rate_nxt;
      end
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   always_comb begin
      rd_val = ctrl_r & pmb_pkg::CTRL_WMASK;
      if (!ctrl_r[pmb_pkg::BIT_OE]) begin
         rd_val[pmb_pkg::BIT_DATA] = mdio_line;
      end
      rd_val[pmb_pkg::BIT_DPX_ST]  = dpx_r;
      rd_val[pmb_pkg::BIT_RATE_LO] = rate_r[0];
      rd_val[pmb_pkg::BIT_RATE_HI] = rate_r[1];
   end

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_reg_rdata  <= 8'h00;
         o_reg_rvalid <= 1'b0;
      end else begin
         o_reg_rvalid <= i_reg_rd;
         if (i_reg_rd) begin
            o_reg_rdata <= sel ? rd_val : 8'h00;
         end
      end
   end

endmodule

// ### bench/pmb_chk.sv
// Purpose: Port assertions for the management port.
// Assumes: Control register at one byte offset.
// Notes:   Polarity bits are shadowed from register writes.
module pmb_chk (
   input wire logic       i_core_clk,
   input wire logic       i_rstn,
   input wire logic [7:0] i_reg_addr,
   input wire logic       i_reg_wr,
   input wire logic       i_reg_rd,
   input wire logic [7:0] i_reg_wdata,
   input wire logic [7:0] o_reg_rdata,
   input wire logic       o_mdc,
   input wire logic       i_mdio_in,
   input wire logic       o_mdio_out,
   input wire logic       o_mdio_oe,
   input wire logic       o_pcs_mdc,
   input wire logic       o_pcs_mdio,
   input wire logic       i_pcs_mdio_oe,
   input wire logic       i_duplex_indication_pin,
   input wire logic       i_link_10_indication_pin,
   input wire logic       i_link_100_indication_pin,
   input wire logic       i_link_1000_indication_pin,
   input wire logic       o_duplex_full,
   input wire logic [1:0] o_link_rate
);
   timeunit 1ns;
   timeprecision 100ps;
   logic       wr_hit;
   logic       rd_hit;
   logic       dpol_r;
   logic       lpol_r;
   logic [2:0] act;
   logic [1:0] rate_exp;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rstn);
   assign wr_hit = i_reg_wr && i_reg_addr == pmb_pkg::CTRL_OFFSET;
   assign rd_hit = i_reg_rd && i_reg_addr == pmb_pkg::CTRL_OFFSET;
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         dpol_r <= 1'b0;
         lpol_r <= 1'b0;
      end else if (wr_hit) begin
         dpol_r <= i_reg_wdata[3];
         lpol_r <= i_reg_wdata[5];
      end
   end
   assign act = {i_link_1000_indication_pin, i_link_100_indication_pin,
                 i_link_10_indication_pin} ^ {3{!lpol_r}};
   assign rate_exp = act[2] ? 2'h3 : act[1] ? 2'h2 : {1'b0, act[0]};
   clk_follow_a:
      assert property (wr_hit |=> o_mdc == $past(i_reg_wdata[0]))
      else $error("clock line differs from written bit");
   pcs_clk_a:
      assert property (o_pcs_mdc == o_mdc
         && (!o_mdio_oe || o_pcs_mdio == o_mdio_out))
      else $error("internal side differs from external pins");
   drive_val_a:
      assert property (wr_hit |=> o_mdio_out == $past(i_reg_wdata[1]))
      else $error("data drive differs from written bit");
   drive_en_a:
      assert property (wr_hit |=> o_mdio_oe == $past(i_reg_wdata[2]))
      else $error("data enable differs from written bit");
   line_read_a:
      assert property ($stable(i_mdio_in)[*4] ##0 (rd_hit && !o_mdio_oe
         && !i_pcs_mdio_oe) |=> o_reg_rdata[1] == $past(i_mdio_in))
      else $error("released data bit does not read the line");
   status_read_a:
      assert property (rd_hit |=> o_reg_rdata[4] == $past(o_duplex_full)
         && o_reg_rdata[7:6] == $past(o_link_rate))
      else $error("status bits differ from status outputs");
   duplex_a:
      assert property (($stable(i_duplex_indication_pin) && $stable(dpol_r))[*5]
         |-> o_duplex_full == (i_duplex_indication_pin ~^ dpol_r))
      else $error("duplex state wrong for pin and polarity");
   link_rate_a:
      assert property (($stable(act) && $stable(lpol_r))[*5]
         |-> o_link_rate == rate_exp)
      else $error("link rate wrong for pins and polarity");
   cover property (wr_hit ##1 o_mdio_oe);
   cover property (o_link_rate == 2'h3);
   cover property (rd_hit && !o_mdio_oe);
endmodule

// ### bench/pmb_phy_model.sv
// Purpose: Far-side device answering on the serial data line.
// Assumes: Line has a pull-up while nobody drives it.
// Notes:   Shifts a fixed pattern out on each clock rise while enabled and not driven by the host.
module pmb_phy_model (
   input  wire logic i_mdc,
   input  wire logic i_oe,
   input  wire logic i_dout,
   input  wire logic i_en,
   output logic      o_line,
   output logic [15:0] o_rx
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] shift_r = 4'hA;
   always @(posedge i_mdc) begin
      if (!i_oe && i_en) begin
         shift_r <= {shift_r[2:0], shift_r[3]};
      end
   end
   // Bits the host drives are taken on each clock rise.
   always @(posedge i_mdc) begin
      if (i_oe) begin
         o_rx <= {o_rx[14:0], i_dout};
      end
   end
   assign o_line = i_oe ? i_dout : (i_en ? shift_r[3] : 1'b1);
endmodule

// ### bench/testbench.sv
// Purpose: Register-level test of the management port.
// Assumes: Inputs change on the falling clock edge.
// Notes:   Serial clock is made by timed register writes.
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic             clk;
   logic             rstn;
   logic [7:0]       addr;
   logic             wr;
   logic             rd;
   logic [7:0]       wdata;
   logic [7:0]       rdata;
   logic             rvalid;
   logic             mdc;
   logic             line;
   logic             mout;
   logic             moe;
   logic             phy_en;
   logic             pcs_out;
   logic             pcs_oe;
   logic             pcs_mdio;
   logic             dpx_full;
   logic [1:0]       link_rate;
   logic [15:0]      rx;
   pmb_pkg::pmb_ind_t pins;
   int               mismatches;
   int               comparisons;
   pmb_mgmt_port u_dut (.i_core_clk(clk), .i_rstn(rstn), .i_reg_addr(addr),
      .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
      .o_reg_rvalid(rvalid), .o_mdc(mdc), .i_mdio_in(line), .o_mdio_out(mout),
      .o_mdio_oe(moe), .o_pcs_mdc(), .o_pcs_mdio(pcs_mdio),
      .i_pcs_mdio_out(pcs_out), .i_pcs_mdio_oe(pcs_oe),
      .i_duplex_indication_pin(pins.duplex),
      .i_link_10_indication_pin(pins.link_10),
      .i_link_100_indication_pin(pins.link_100),
      .i_link_1000_indication_pin(pins.link_1000),
      .o_duplex_full(dpx_full), .o_link_rate(link_rate));
   pmb_phy_model u_phy (.i_mdc(mdc), .i_oe(moe), .i_dout(mout), .i_en(phy_en),
      .o_line(line), .o_rx(rx));
   task automatic print_verdict;
      $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
      @(negedge clk);
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
      int n;
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      for (n = 0; n < 4 && rvalid !== 1'b1; n++) @(negedge clk);
      if (n == 4) begin
         mismatches++;
         print_verdict();
      end else begin
         chk(rdata, exp);
         @(negedge clk);
      end
   endtask
   task automatic send_bits(input logic [15:0] v);
      for (int i = 15; i >= 0; i--) begin
         wr_reg(8'h76, {5'h00, 1'b1, v[i], 1'b0});
         repeat (6) @(negedge clk);
         wr_reg(8'h76, {5'h00, 1'b1, v[i], 1'b1});
         repeat (6) @(negedge clk);
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      rstn = 1'b0;
      addr = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      wdata = 8'h00;
      phy_en = 1'b0;
      pcs_out = 1'b0;
      pcs_oe = 1'b0;
      pins = 4'hF;
      mismatches = 0;
      comparisons = 0;
      repeat (4) @(negedge clk);
      rstn = 1'b1;
      rd_reg(8'h76, 8'h02);
      wr_reg(8'h76, 8'hFF);
      chk({mdc, mout, moe, 5'h00}, 8'hE0);
      repeat (5) @(negedge clk);
      rd_reg(8'h76, 8'hFF);
      wr_reg(8'h77, 8'h00);
      rd_reg(8'h77, 8'h00);
      rd_reg(8'h76, 8'hFF);
      wr_reg(8'h76, 8'h00);
      phy_en = 1'b1;
      for (int k = 0; k < 4; k++) begin
         pins = ~(4'h8 | ((4'h7 << (3 - k)) & 4'h7));
         repeat (5) @(negedge clk);
         chk({dpx_full, link_rate, 5'h00}, {1'b1, k[1:0], 5'h00});
         rd_reg(8'h76, {k[1:0], 6'h12});
      end
      for (int n = 1; n < 5; n++) begin
         wr_reg(8'h76, 8'h01);
         repeat (12) @(negedge clk);
         rd_reg(8'h76, {6'h34, ~n[0], 1'b1});
         wr_reg(8'h76, 8'h00);
         repeat (8) @(negedge clk);
      end
      pcs_oe = 1'b1;
      rd_reg(8'h76, 8'hD0);
      chk({7'h00, pcs_mdio}, 8'h01);
      pcs_oe = 1'b0;
      send_bits(16'hFFFF);
      send_bits(16'hFFFF);
      send_bits(16'h508A);
      send_bits(16'hA5C3);
      wr_reg(8'h76, 8'h00);
      chk(rx[15:8], 8'hA5);
      chk(rx[7:0], 8'hC3);
      print_verdict();
   end
endmodule
bind pmb_mgmt_port pmb_chk u_chk (.*);
